/* File: hw/rcg_pkg.sv */
// Package of constants for the remote input command gate.
// Assumes a single 10 MHz clock domain and AXI4-Lite register access.
package rcg_pkg;
  // ****************************************************************
  // Register map (byte addresses).
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MAP_LO = 8'h04;
  localparam logic [7:0] ADDR_MAP_HI = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_PROGRAM = 8'h18;
  // ****************************************************************
  // Control register fields.
  // ****************************************************************
  localparam int CTRL_REMOTE_BIT = 0;
  localparam int CTRL_VIO_BIT = 1;
  localparam int CTRL_MAPPED_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // ****************************************************************
  // Function slots and default input numbers.
  // ****************************************************************
  localparam int NUM_GEN_IN = 24;
  localparam int NUM_FUNC = 13;
  localparam int IDX_W = 5;
  localparam logic [4:0] UNSET = 5'h1F;
  localparam int F_START = 0;
  localparam int F_SEL0 = 1;
  localparam int F_STOP = 7;
  localparam int F_PAUSE = 8;
  localparam int F_CONT = 9;
  localparam int F_RESET = 10;
  localparam int F_FLP = 11;
  localparam int F_SPARE = 12;
  localparam int NUM_SEL = 6;
  localparam int MAP_LO_SLOTS = 6;
  localparam logic [64:0] MAP_DEFAULT = {
    5'h1F, 5'h1F, 5'h07, 5'h06, 5'h05, 5'h04,
    5'h1F, 5'h1F, 5'h1F, 5'h03, 5'h02, 5'h01, 5'h00};
  // ****************************************************************
  // Interrupt events.
  // ****************************************************************
  localparam int NUM_EV = 6;
  localparam int EV_START = 0;
  localparam int EV_STOP = 1;
  localparam int EV_PAUSE = 2;
  localparam int EV_CONT = 3;
  localparam int EV_RESET = 4;
  localparam int EV_FLP = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rcg_pkg

/* File: hw/rcg_sync.sv */
// Two-flop synchroniser with rising-edge detect, one per bit.
// Assumes inputs come from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module rcg_sync #(
  parameter int W = 24
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out,
  output logic [W-1:0] rise_out
);
  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] prev;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end else if (ce_in) begin
      meta <= async_in;
      sync <= meta;
      prev <= sync;
    end
  end
  assign level_out = sync;
  assign rise_out = sync & ~prev;
endmodule : rcg_sync
`default_nettype wire

/* File: hw/rcg_gate.sv */
// Remote input command gate: maps general inputs onto remote functions,
// judges each onset against controller status and issues command pulses.
// Assumes status inputs are synchronous to clk_in; general inputs are not.
`timescale 1ns/1ps
`default_nettype none
module rcg_gate
  import rcg_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic [NUM_GEN_IN-1:0] gen_in,
  input wire logic ready_in,
  input wire logic running_in,
  input wire logic paused_in,
  input wire logic error_in,
  input wire logic emergency_stop_active_in,
  input wire logic emergency_stop_released_in,
  input wire logic guard_open_status_in,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic remote_auto_status_out,
  output logic start_cmd_out,
  output logic [5:0] program_number_out,
  output logic stop_cmd_out,
  output logic pause_cmd_out,
  output logic continue_cmd_out,
  output logic reset_cmd_out,
  output logic forced_low_power_input_out,
  output logic irq_out
);
  // ****************************************************************
  // Input synchronisation.
  // ****************************************************************
  logic [NUM_GEN_IN-1:0] lvl;
  logic [NUM_GEN_IN-1:0] rise;
  rcg_sync #(.W(NUM_GEN_IN)) u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .async_in(gen_in),
    .level_out(lvl),
    .rise_out(rise)
  );

  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic [2:0] ctrl;
  logic [64:0] map;
  logic [NUM_EV-1:0] irq_stat;
  logic [NUM_EV-1:0] irq_mask;
  logic [2:0] next_ctrl;
  logic [64:0] next_map;
  logic [NUM_EV-1:0] next_irq_stat;
  logic [NUM_EV-1:0] next_irq_mask;

  // Returns the input number held for one function slot.
  function automatic logic [IDX_W-1:0] slot_idx(input logic [64:0] m, input int f);
    slot_idx = m[f*IDX_W +: IDX_W];
  endfunction : slot_idx

  // Picks a synchronised bit by input number; unset numbers read low.
  function automatic logic pick(input logic [NUM_GEN_IN-1:0] v, input logic [IDX_W-1:0] i);
    pick = (i < IDX_W'(NUM_GEN_IN)) ? v[i] : 1'b0;
  endfunction : pick

  // ****************************************************************
  // Function decode.
  // ****************************************************************
  logic [NUM_FUNC-1:0] f_lvl;
  logic [NUM_FUNC-1:0] f_rise;
  genvar g;
  generate
    for (g = 0; g < NUM_FUNC; g++) begin : g_fn
      assign f_lvl[g] = pick(lvl, slot_idx(map, g));
      assign f_rise[g] = pick(rise, slot_idx(map, g));
    end
  endgenerate

  logic auto_on;
  logic ok_start;
  logic ok_stop;
  logic ok_pause;
  logic ok_cont;
  logic ok_reset;
  // Auto mode needs remote selected, functions mapped and virtual I/O on.
  assign auto_on = ctrl[CTRL_REMOTE_BIT] & ctrl[CTRL_MAPPED_BIT]
                 & ctrl[CTRL_VIO_BIT];
  assign ok_start = auto_on & ~error_in & ready_in & ~emergency_stop_active_in
                  & ~guard_open_status_in & emergency_stop_released_in
                  & ~f_lvl[F_PAUSE] & ~f_lvl[F_STOP];
  assign ok_stop = auto_on & ~error_in;
  assign ok_pause = auto_on & ~error_in & running_in;
  assign ok_cont = auto_on & ~error_in & paused_in
                 & ~f_lvl[F_PAUSE] & ~f_lvl[F_STOP];
  assign ok_reset = auto_on & ready_in;

  logic next_start;
  logic next_stop;
  logic next_pause;
  logic next_cont;
  logic next_reset;
  logic next_flp;
  logic [5:0] next_prog;
  always_comb begin
    next_start = f_rise[F_START] & ok_start;
    next_stop = f_rise[F_STOP] & ok_stop;
    next_pause = f_rise[F_PAUSE] & ok_pause;
    next_cont = f_rise[F_CONT] & ok_cont;
    next_reset = f_rise[F_RESET] & ok_reset;
    next_flp = f_lvl[F_FLP];
    next_prog = program_number_out;
    if (next_start) begin
      next_prog = f_lvl[F_SEL0 +: NUM_SEL];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      start_cmd_out <= 1'b0;
      stop_cmd_out <= 1'b0;
      pause_cmd_out <= 1'b0;
      continue_cmd_out <= 1'b0;
      reset_cmd_out <= 1'b0;
      forced_low_power_input_out <= 1'b0;
      program_number_out <= 6'h00;
      remote_auto_status_out <= 1'b0;
    end else if (ce_in) begin
      start_cmd_out <= next_start;
      stop_cmd_out <= next_stop;
      pause_cmd_out <= next_pause;
      continue_cmd_out <= next_cont;
      reset_cmd_out <= next_reset;
      forced_low_power_input_out <= next_flp;
      program_number_out <= next_prog;
      remote_auto_status_out <= auto_on;
    end
  end

  // ****************************************************************
  // AXI4-Lite slave.
  // ****************************************************************
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic next_w_held;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [1:0] next_rresp;
  logic [31:0] next_rdata;
  logic wr_go;
  logic [31:0] wmask;
  logic [NUM_EV-1:0] events;

  // Nothing is taken while the clock enable freezes the state.
  assign s_axi_awready = ce_in & ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ce_in & ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ce_in & ~s_axi_rvalid;
  assign wr_go = aw_held & w_held & ~s_axi_bvalid;
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign events = {next_flp & ~forced_low_power_input_out, next_reset, next_cont,
                   next_pause, next_stop, next_start};

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid & ~s_axi_bready;
    next_bresp = s_axi_bresp;
    next_ctrl = ctrl;
    next_map = map;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (aw_addr)
        ADDR_CTRL: next_ctrl = ((ctrl & ~wmask[2:0]) | (w_data[2:0] & wmask[2:0]));
        ADDR_MAP_LO: next_map[29:0] = (map[29:0] & ~wmask[29:0]) | (w_data[29:0] & wmask[29:0]);
        // The spare slot above bit 59 is not writable and stays unassigned.
        ADDR_MAP_HI: next_map[59:30] = (map[59:30] & ~wmask[29:0]) | (w_data[29:0] & wmask[29:0]);
        ADDR_IRQ_STAT: next_irq_stat = irq_stat & ~(w_data[NUM_EV-1:0] & wmask[NUM_EV-1:0]);
        ADDR_IRQ_MASK: next_irq_mask = (irq_mask & ~wmask[NUM_EV-1:0])
                                     | (w_data[NUM_EV-1:0] & wmask[NUM_EV-1:0]);
        ADDR_STATUS, ADDR_PROGRAM: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    // Set wins over a clear in the same cycle.
    next_irq_stat = next_irq_stat | events;
  end

  always_comb begin
    next_rvalid = s_axi_rvalid & ~s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0000_0000;
      case (s_axi_araddr[7:0])
        ADDR_CTRL: next_rdata[2:0] = ctrl;
        ADDR_MAP_LO: next_rdata[29:0] = map[29:0];
        ADDR_MAP_HI: next_rdata[29:0] = map[59:30];
        ADDR_STATUS: next_rdata = {{24{1'b0}}, lvl[7:0]} | {23'h0, remote_auto_status_out, 8'h00};
        ADDR_IRQ_STAT: next_rdata[NUM_EV-1:0] = irq_stat;
        ADDR_IRQ_MASK: next_rdata[NUM_EV-1:0] = irq_mask;
        ADDR_PROGRAM: next_rdata[5:0] = program_number_out;
        default: next_rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      ctrl <= CTRL_RESET;
      map <= MAP_DEFAULT;
      irq_stat <= '0;
      irq_mask <= '0;
    end else if (ce_in) begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      ctrl <= next_ctrl;
      map <= next_map;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
    end
  end

  assign irq_out = |(irq_stat & irq_mask);

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  property p_start_gate;
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && $rose(start_cmd_out) |-> $past(ok_start) && !$past(error_in);
  endproperty
  a_start_gate: assert property (p_start_gate) else $error("start without condition");
  property p_stop_err;
    @(posedge clk_in) disable iff (!nrst_in)
    stop_cmd_out |-> $past(auto_on) && !$past(error_in);
  endproperty
  a_stop_err: assert property (p_stop_err) else $error("stop during error");
  property p_pause_run;
    @(posedge clk_in) disable iff (!nrst_in)
    pause_cmd_out |-> $past(running_in);
  endproperty
  a_pause_run: assert property (p_pause_run) else $error("pause while not running");
  property p_cont_cond;
    @(posedge clk_in) disable iff (!nrst_in)
    continue_cmd_out |-> $past(paused_in) && !$past(f_lvl[F_PAUSE]);
  endproperty
  a_cont_cond: assert property (p_cont_cond) else $error("continue gated wrong");
  property p_reset_ready;
    @(posedge clk_in) disable iff (!nrst_in)
    reset_cmd_out |-> $past(ready_in) && $past(auto_on);
  endproperty
  a_reset_ready: assert property (p_reset_ready) else $error("reset while not ready");
  property p_one_pulse;
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && start_cmd_out ##1 ce_in |-> !start_cmd_out;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("start pulse too long");
  property p_auto;
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && auto_on |=> remote_auto_status_out;
  endproperty
  a_auto: assert property (p_auto) else $error("auto status missing");
  property p_prog;
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in && next_start |=> program_number_out == $past(f_lvl[F_SEL0 +: NUM_SEL]);
  endproperty
  a_prog: assert property (p_prog) else $error("program number wrong");
  property p_flp_follow;
    @(posedge clk_in) disable iff (!nrst_in)
    ce_in |=> forced_low_power_input_out == $past(f_lvl[F_FLP]);
  endproperty
  a_flp_follow: assert property (p_flp_follow) else $error("forced low power not followed");
endmodule : rcg_gate
`default_nettype wire

/* File: verification/rcg_seq_model.sv */
// Behavioural sequencer that drives the gate's general input pins.
// Assumes bench requests change just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module rcg_seq_model (
  input wire logic clk_in,
  input wire logic [23:0] hold_in,
  input wire logic [5:0] sel_in,
  output logic [23:0] pins_out
);
  // ****
  // Pin drive
  // ****
  // Select bits 0 to 2 sit on the default pins; bits 3 to 5 sit on pins 9 to 11.
  // The upper three only count once software maps them.
  always @(posedge clk_in) begin
    pins_out <= {hold_in[23:12], sel_in[5:3], hold_in[8:4], sel_in[2:0], hold_in[0]};
  end
endmodule : rcg_seq_model
`default_nettype wire

/* File: verification/remote_input_command_gate_tb_top.sv */
// Self-checking bench for the remote input command gate.
// Assumes the default input mapping and a sequencer model on the pins.
`timescale 1ns/1ps
`default_nettype none
module remote_input_command_gate_tb_top;
  import rcg_pkg::*;
  typedef struct packed {
    logic [4:0] pin;
    logic [6:0] st;
    logic [5:0] sel;
    logic [4:0] exp;
  } rcg_row_type;
  logic clk_in, nrst_in, ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, auto_on, irq;
  logic start_p, stop_p, pause_p, cont_p, reset_p, flp;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [23:0] hold, pins;
  logic [6:0] st;
  logic [5:0] sel, prog;
  int mismatches, samples_checked;
  // Status order is ready, running, paused, error, estop on, estop off, guard.
  rcg_row_type rows [17] = '{
    '{5'h00, 7'h42, 6'h05, 5'h10}, '{5'h00, 7'h43, 6'h07, 5'h00},
    '{5'h00, 7'h46, 6'h01, 5'h00}, '{5'h00, 7'h40, 6'h02, 5'h00},
    '{5'h00, 7'h4A, 6'h03, 5'h00}, '{5'h00, 7'h02, 6'h04, 5'h00},
    '{5'h00, 7'h42, 6'h07, 5'h10}, '{5'h04, 7'h00, 6'h00, 5'h08},
    '{5'h04, 7'h08, 6'h00, 5'h00}, '{5'h05, 7'h20, 6'h00, 5'h04},
    '{5'h05, 7'h00, 6'h00, 5'h00}, '{5'h05, 7'h28, 6'h00, 5'h00},
    '{5'h06, 7'h10, 6'h00, 5'h02}, '{5'h06, 7'h00, 6'h00, 5'h00},
    '{5'h07, 7'h40, 6'h00, 5'h01}, '{5'h07, 7'h48, 6'h00, 5'h01},
    '{5'h07, 7'h08, 6'h00, 5'h00}};

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  rcg_seq_model seq_u (.clk_in(clk_in), .hold_in(hold), .sel_in(sel), .pins_out(pins));

  rcg_gate dut_u (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce), .gen_in(pins),
    .ready_in(st[6]), .running_in(st[5]), .paused_in(st[4]), .error_in(st[3]),
    .emergency_stop_active_in(st[2]), .emergency_stop_released_in(st[1]),
    .guard_open_status_in(st[0]), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .remote_auto_status_out(auto_on), .start_cmd_out(start_p), .program_number_out(prog),
    .stop_cmd_out(stop_p), .pause_cmd_out(pause_p), .continue_cmd_out(cont_p),
    .reset_cmd_out(reset_p), .forced_low_power_input_out(flp), .irq_out(irq));

  // ****
  // Helpers
  // ****
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask : settle

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    int n;
    b = 1'b0;
    n = 0;
    @(posedge clk_in);
    awaddr <= {24'h000000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b && n < 50) begin
      @(negedge clk_in);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      r = bresp;
      n++;
      @(posedge clk_in);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!b) mismatches++;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    int n;
    v = 1'b0;
    n = 0;
    @(posedge clk_in);
    araddr <= {24'h000000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!v && n < 50) begin
      @(negedge clk_in);
      ar = arvalid & arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      n++;
      @(posedge clk_in);
      if (ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!v) mismatches++;
  endtask : axi_rd

  task automatic run_cmd(input rcg_row_type r);
    logic [4:0] seen;
    int cnt;
    seen = '0;
    cnt = 0;
    @(posedge clk_in);
    st <= r.st;
    sel <= r.sel;
    repeat (5) @(posedge clk_in);
    hold[r.pin] <= 1'b1;
    repeat (12) begin
      @(negedge clk_in);
      seen = seen | {start_p, stop_p, pause_p, cont_p, reset_p};
      cnt = cnt + $countones({start_p, stop_p, pause_p, cont_p, reset_p});
    end
    @(posedge clk_in);
    hold <= '0;
    repeat (4) @(posedge clk_in);
    chk("pulses", {27'h0, r.exp}, {27'h0, seen});
    chk("pulse_count", $countones(r.exp), cnt);
    if (r.exp[4]) chk("program", {26'h0, r.sel}, {26'h0, prog});
  endtask : run_cmd

  task automatic blocked(input int p, input rcg_row_type r);
    @(posedge clk_in);
    hold[p] <= 1'b1;
    repeat (8) @(posedge clk_in);
    run_cmd(r);
  endtask : blocked

  task automatic results();
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  initial begin
    #1000000;
    mismatches++;
    results();
  end

  // ****
  // Main sequence
  // ****
  initial begin
    nrst_in = 1'b0;
    ce = 1'b1;
    st = '0;
    sel = '0;
    hold = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    wdata = '0;
    araddr = '0;
    mismatches = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    settle(1);
    chk("outs_rst", 0, {auto_on, irq, flp, start_p, stop_p, pause_p, cont_p, reset_p});
    axi_rd(ADDR_CTRL, rd, resp);
    chk("ctrl_rst", {29'h0, CTRL_RESET}, rd);
    axi_rd(ADDR_MAP_LO, rd, resp);
    chk("map_lo", {2'h0, MAP_DEFAULT[29:0]}, {2'h0, rd[29:0]});
    run_cmd('{5'h04, 7'h00, 6'h00, 5'h00});
    axi_wr(ADDR_CTRL, 32'h00000005, resp);
    settle(2);
    chk("auto_novio", 0, auto_on);
    axi_wr(ADDR_CTRL, 32'h00000006, resp);
    settle(2);
    chk("auto_noremote", 0, auto_on);
    axi_wr(ADDR_CTRL, 32'h00000003, resp);
    settle(2);
    chk("auto_unmapped", 0, auto_on);
    axi_wr(ADDR_CTRL, 32'h00000007, resp);
    chk("bresp", RESP_OKAY, resp);
    settle(2);
    chk("auto", 1, auto_on);
    axi_rd(ADDR_STATUS, rd, resp);
    chk("status_auto", 1, rd[8]);
    foreach (rows[i]) run_cmd(rows[i]);
    blocked(4, '{5'h00, 7'h42, 6'h00, 5'h00});
    blocked(5, '{5'h06, 7'h10, 6'h00, 5'h00});
    axi_rd(ADDR_IRQ_STAT, rd, resp);
    chk("irq_stat", 32'h0000001F, rd);
    chk("irq_masked", 0, irq);
    axi_wr(ADDR_IRQ_MASK, 32'h0000003F, resp);
    settle(1);
    chk("irq_on", 1, irq);
    axi_wr(ADDR_IRQ_STAT, 32'h0000001F, resp);
    settle(1);
    chk("irq_clr", 0, irq);
    axi_rd(8'h1C, rd, resp);
    chk("rresp_bad", RESP_SLVERR, resp);
    axi_wr(8'h20, 32'h00000000, resp);
    chk("bresp_bad", RESP_SLVERR, resp);
    axi_wr(ADDR_MAP_HI, {2'h3, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h0B}, resp);
    axi_rd(ADDR_MAP_HI, rd, resp);
    chk("map_hi", {2'h0, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h0B}, rd);
    axi_wr(ADDR_MAP_LO, {2'h0, 5'h0A, 5'h09, 5'h03, 5'h02, 5'h01, 5'h00}, resp);
    run_cmd('{5'h00, 7'h42, 6'h2D, 5'h10});
    axi_wr(ADDR_IRQ_STAT, 32'h00000001, resp);
    axi_wr(ADDR_CTRL, 32'h00000000, resp);
    @(posedge clk_in);
    hold[8] <= 1'b1;
    settle(6);
    chk("flp_on", 1, flp);
    chk("irq_flp", 1, irq);
    axi_rd(ADDR_IRQ_STAT, rd, resp);
    chk("irq_stat_flp", 32'h00000020, rd);
    hold <= '0;
    settle(6);
    chk("flp_off", 0, flp);
    @(posedge clk_in);
    ce <= 1'b0;
    hold[8] <= 1'b1;
    settle(6);
    chk("flp_frozen", 0, flp);
    @(posedge clk_in);
    ce <= 1'b1;
    settle(6);
    chk("flp_thaw", 1, flp);
    @(posedge clk_in);
    hold <= '0;
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    settle(1);
    chk("irq_rst2", 0, irq);
    axi_rd(ADDR_CTRL, rd, resp);
    chk("ctrl_rst2", 0, rd);
    results();
  end
endmodule : remote_input_command_gate_tb_top
`default_nettype wire
